// ---- core/urx_map.vh ----
// Register map, field positions and reset values of the receive error block
//
// Overview of operation
// - Error status register is read-only, resets to 00h, bits 7..3 read zero.
// - Parity and framing flags clear on power off, receive off, or status read.
// - Parity flag sets at end of reception when received parity disagrees.
// - Framing flag sets at end of reception when stop bit is not high.
// - Overrun sets on completion with buffer unread; clears on read or both enables off.
// - Parity checking follows the two-bit parity mode field.
// - Only the first stop-bit position is checked on reception.
// - On overrun the new character is dropped; receive buffer keeps old data.
// - Status register read gets a wait cycle; software avoids it with clock stopped.
// - Baud control resets 1Fh; bits 7:6 pick timer, /2, /8, /32; bit 5 zero.
// - Divisor field bits 4:0 divide base clock by k, 8 to 31.
// - Baud rate is the divisor counter output halved.
// - Port 3 direction bit 0 drives the pin, 1 makes it an input.
// - Port 3 direction resets to FFh; bits 7..5 stay one.
// - Zero-parity reception never checks parity nor sets the parity flag.
`ifndef URX_MAP_VH
`define URX_MAP_VH

// ======================================
// Register indices, byte address is four times the index
`define URX_IDX_W         16
`define URX_IDX_PORT3_DIR 16'hFF23
`define URX_IDX_PORT3_LAT 16'hFF03
`define URX_IDX_MODE      16'hFF50
`define URX_IDX_BAUD      16'hFF51
`define URX_IDX_RXBUF     16'hFF52
`define URX_IDX_ERR       16'hFF53

// ======================================
// Decoded register select, one bit each
`define URX_NSEL   6
`define URX_S_DIR  0
`define URX_S_LAT  1
`define URX_S_MODE 2
`define URX_S_BAUD 3
`define URX_S_RXB  4
`define URX_S_ERR  5

// ======================================
// Reset values and fixed bits
`define URX_RST_MODE  8'h01
`define URX_RST_BAUD  8'h1F
`define URX_RST_DIR   5'h1F
`define URX_RST_LAT   5'h00
`define URX_RST_RXBUF 8'hFF
`define URX_MODE_WMSK 8'hFE
`define URX_MODE_FIX  8'h01
`define URX_BAUD_WMSK 8'hDF
`define URX_DIR_FIX   3'h7

// ======================================
// Field positions
`define URX_M_POWER 7
`define URX_M_TXE   6
`define URX_M_RXE   5
`define URX_M_PARH  4
`define URX_M_PARL  3
`define URX_M_CL8   2
`define URX_B_SELH  7
`define URX_B_SELL  6
`define URX_B_DIVH  4
`define URX_B_DIVL  0
`define URX_E_PE    2
`define URX_E_FE    1
`define URX_E_OVE   0
`define URX_P3_N    5
`define URX_TX_PIN  1
`define URX_RX_PIN  2

// ======================================
// Encodings and counts
`define URX_PAR_NONE 2'h0
`define URX_PAR_ZERO 2'h1
`define URX_PAR_ODD  2'h2
`define URX_PAR_EVEN 2'h3
`define URX_SEL_TMR  2'h0
`define URX_SEL_D2   2'h1
`define URX_SEL_D8   2'h2
`define URX_SEL_D32  2'h3
`define URX_PRE_D2   5'h01
`define URX_PRE_D8   5'h07
`define URX_PRE_D32  5'h1F
`define URX_LAST8    4'h7
`define URX_LAST7    4'h6
`define URX_HSIZE_W  3'h2

`endif

// ---- core/urx_baud_gen.v ----
// Base clock selection, five-bit divisor counter and baud halving
`include "urx_map.vh"
module urx_baud_gen (
	// Clock, reset, enable
	input  wire       clock,
	input  wire       resetn,
	input  wire       clockEn,
	// Control
	input  wire       run,
	input  wire [1:0] baseSel,
	input  wire [4:0] divisor,
	input  wire       timerOut,
	// Ticks
	output reg        halfTick,
	output reg        baudTick
);

	reg  [4:0] preQ;
	reg        timerPrevQ;
	reg  [4:0] cntQ;
	reg        halfQ;
	reg        baseTick;
	wire [4:0] lastCnt = divisor - 5'h01;

	// ======================================
	// Base clock pick
	always @* begin
		case (baseSel)
			`URX_SEL_TMR: baseTick = timerOut & ~timerPrevQ;
			`URX_SEL_D2:  baseTick = (preQ & `URX_PRE_D2) == `URX_PRE_D2;
			`URX_SEL_D8:  baseTick = (preQ & `URX_PRE_D8) == `URX_PRE_D8;
			default:      baseTick = (preQ & `URX_PRE_D32) == `URX_PRE_D32;
		endcase
	end

	// ======================================
	// Divide by k, then halve
	// Divisor is read live, so a change mid-frame bends one period
	always @(posedge clock) begin
		if (!resetn) begin
			preQ       <= 5'h00;
			timerPrevQ <= 1'b0;
			cntQ       <= 5'h00;
			halfQ      <= 1'b0;
			halfTick   <= 1'b0;
			baudTick   <= 1'b0;
		end else if (clockEn) begin
			timerPrevQ <= timerOut;
			halfTick   <= 1'b0;
			baudTick   <= 1'b0;
			if (!run) begin
				preQ  <= 5'h00;
				cntQ  <= 5'h00;
				halfQ <= 1'b0;
			end else begin
				preQ <= preQ + 5'h01;
				if (baseTick) begin
					if (cntQ == lastCnt) begin
						cntQ     <= 5'h00;
						halfTick <= 1'b1;
						halfQ    <= ~halfQ;
						baudTick <= halfQ;
					end else begin
						cntQ <= cntQ + 5'h01;
					end
				end
			end
		end
	end

endmodule // urx_baud_gen

// ---- core/urx_rx_frame.v ----
// Receive framing: start detect, data, parity and first stop bit
`include "urx_map.vh"
module urx_rx_frame (
	// Clock, reset, enable
	input  wire       clock,
	input  wire       resetn,
	input  wire       clockEn,
	// Control
	input  wire       enable,
	input  wire       halfTick,
	input  wire       rxLine,
	input  wire       charLen8,
	input  wire       parityOn,
	// Completed character
	output reg        done,
	output reg  [7:0] data,
	output reg        parityBit,
	output reg        stopOk
);

	localparam [4:0] S_IDLE  = 5'h01;
	localparam [4:0] S_START = 5'h02;
	localparam [4:0] S_DATA  = 5'h04;
	localparam [4:0] S_PAR   = 5'h08;
	localparam [4:0] S_STOP  = 5'h10;

	reg  [4:0] stateQ;
	reg        phaseQ;
	reg  [3:0] bitCntQ;
	reg  [7:0] shiftQ;
	wire       sampleNow = halfTick & phaseQ;
	wire [3:0] lastBit = charLen8 ? `URX_LAST8 : `URX_LAST7;

	always @(posedge clock) begin
		if (!resetn) begin
			stateQ    <= S_IDLE;
			phaseQ    <= 1'b0;
			bitCntQ   <= 4'h0;
			shiftQ    <= 8'h00;
			done      <= 1'b0;
			data      <= 8'h00;
			parityBit <= 1'b0;
			stopOk    <= 1'b0;
		end else if (clockEn) begin
			done <= 1'b0;
			if (halfTick)
				phaseQ <= ~phaseQ;
			if (!enable) begin
				stateQ <= S_IDLE;
				phaseQ <= 1'b0;
			end else begin
				case (stateQ)
					S_IDLE: begin
						if (halfTick && !rxLine)
							stateQ <= S_START;
					end
					S_START: begin
						// Half a bit later the start bit must still be low
						if (halfTick) begin
							stateQ  <= rxLine ? S_IDLE : S_DATA;
							phaseQ  <= 1'b0;
							bitCntQ <= 4'h0;
						end
					end
					S_DATA: begin
						if (sampleNow) begin
							shiftQ  <= {rxLine, shiftQ[7:1]};
							bitCntQ <= bitCntQ + 4'h1;
							if (bitCntQ == lastBit)
								stateQ <= parityOn ? S_PAR : S_STOP;
						end
					end
					S_PAR: begin
						if (sampleNow) begin
							parityBit <= rxLine;
							stateQ    <= S_STOP;
						end
					end
					S_STOP: begin
						// Second stop bit, if any, is never looked at
						if (sampleNow) begin
							stopOk <= rxLine;
							done   <= 1'b1;
							data   <= charLen8 ? shiftQ : {1'b0, shiftQ[7:1]};
							stateQ <= S_IDLE;
						end
					end
					default: stateQ <= S_IDLE;
				endcase
			end
		end
	end

endmodule // urx_rx_frame

// ---- core/urx_top.v ----
// AHB-Lite registers, receive error flags, receive buffer and port 3 pins
`include "urx_map.vh"
module urx_top (
	// Clock, reset, enable
	input  wire        clock,
	input  wire        resetn,
	input  wire        clockEn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	// Port 3 pins
	input  wire [4:0]  p3PinIn,
	output reg  [4:0]  p3PinOut,
	output reg  [4:0]  p3PinOeN,
	// Timer and transmitter hooks
	input  wire        eightBitTimerOutput,
	input  wire        txSerialData,
	output reg         txEnable,
	output wire        baudTick
);

	// ======================================
	// State
	reg  [7:0] modeQ;
	reg  [7:0] baudQ;
	reg  [4:0] dirQ;
	reg  [4:0] latchQ;
	reg  [7:0] rxBufQ;
	reg        rxFullQ;
	reg        parityErrQ;
	reg        framingErrQ;
	reg        overrunQ;
	reg        wrPendQ;
	reg  [5:0] wrSelQ;
	reg        rdWaitQ;
	reg  [5:0] rdSelQ;

	// ======================================
	// Control fields
	wire       powerOn  = modeQ[`URX_M_POWER];
	wire       txOn     = modeQ[`URX_M_TXE];
	wire       rxOn     = modeQ[`URX_M_RXE];
	wire [1:0] parMode  = {modeQ[`URX_M_PARH], modeQ[`URX_M_PARL]};
	wire       charLen8 = modeQ[`URX_M_CL8];
	wire [1:0] baseSel  = {baudQ[`URX_B_SELH], baudQ[`URX_B_SELL]};
	wire [4:0] divisor  = baudQ[`URX_B_DIVH:`URX_B_DIVL];
	wire       rxRun    = powerOn & rxOn;
	wire       parityOn = parMode != `URX_PAR_NONE;

	// ======================================
	// Address decode
	function [5:0] decodeAddr;
		input [31:0] a;
		reg   [15:0] idx;
		begin
			idx = a[17:2];
			decodeAddr = 6'h00;
			if (a[31:18] != 14'h0000 || a[1:0] != 2'h0)
				decodeAddr = 6'h00;
			else if (idx == `URX_IDX_PORT3_DIR)
				decodeAddr[`URX_S_DIR] = 1'b1;
			else if (idx == `URX_IDX_PORT3_LAT)
				decodeAddr[`URX_S_LAT] = 1'b1;
			else if (idx == `URX_IDX_MODE)
				decodeAddr[`URX_S_MODE] = 1'b1;
			else if (idx == `URX_IDX_BAUD)
				decodeAddr[`URX_S_BAUD] = 1'b1;
			else if (idx == `URX_IDX_RXBUF)
				decodeAddr[`URX_S_RXB] = 1'b1;
			else if (idx == `URX_IDX_ERR)
				decodeAddr[`URX_S_ERR] = 1'b1;
		end
	endfunction

	// ======================================
	// Read data
	function [7:0] readMux;
		input [5:0] s;
		begin
			readMux = 8'h00;
			if (s[`URX_S_DIR])
				readMux = {`URX_DIR_FIX, dirQ};
			else if (s[`URX_S_LAT])
				readMux = {3'h0, latchQ};
			else if (s[`URX_S_MODE])
				readMux = modeQ;
			else if (s[`URX_S_BAUD])
				readMux = baudQ & `URX_BAUD_WMSK;
			else if (s[`URX_S_RXB])
				readMux = rxBufQ;
			else if (s[`URX_S_ERR])
				readMux = {5'h00, parityErrQ, framingErrQ, overrunQ};
		end
	endfunction

	// ======================================
	// Parity judgement
	function parityBad;
		input [7:0] d;
		input       cl8;
		input [1:0] mode;
		input       pbit;
		reg         ones;
		begin
			ones = ^(cl8 ? d : {1'b0, d[6:0]}) ^ pbit;
			case (mode)
				`URX_PAR_ODD:  parityBad = ~ones;
				`URX_PAR_EVEN: parityBad = ones;
				default:       parityBad = 1'b0;
			endcase
		end
	endfunction

	// ======================================
	// Bus phases
	wire [5:0] curSel   = decodeAddr(haddr);
	wire       accept   = hsel & htrans[1] & hready;
	wire       rdAccept = accept & ~hwrite;
	wire       wrAccept = accept & hwrite & (hsize == `URX_HSIZE_W);
	// A read right behind a write waits so it sees the new value
	wire       needWait = curSel[`URX_S_ERR] | wrPendQ;
	wire       rdNow    = (rdAccept & ~needWait) | rdWaitQ;
	wire [5:0] rdSel    = rdWaitQ ? rdSelQ : curSel;
	wire       errRead  = rdNow & rdSel[`URX_S_ERR];
	wire       bufRead  = rdNow & rdSel[`URX_S_RXB];
	wire       wrNow    = wrPendQ;

	// Write data phase follows every accepted word write
	always @(posedge clock) begin
		if (!resetn) begin
			wrPendQ <= 1'b0;
			wrSelQ  <= 6'h00;
		end else if (clockEn) begin
			wrPendQ <= wrAccept;
			if (wrAccept)
				wrSelQ <= curSel;
		end
	end

	// Waited read keeps its target for the data phase
	always @(posedge clock) begin
		if (!resetn) begin
			rdWaitQ <= 1'b0;
			rdSelQ  <= 6'h00;
		end else if (clockEn) begin
			rdWaitQ <= rdAccept & needWait & ~rdWaitQ;
			if (rdAccept && needWait && !rdWaitQ)
				rdSelQ <= curSel;
		end
	end

	// Low for exactly the one inserted wait cycle
	always @(posedge clock) begin
		if (!resetn)
			hreadyout <= 1'b1;
		else if (clockEn)
			hreadyout <= rdWaitQ | ~(rdAccept & needWait);
	end

	// Read data stands until the next read loads it
	always @(posedge clock) begin
		if (!resetn)
			hrdata <= 32'h00000000;
		else if (clockEn && rdNow)
			hrdata <= {24'h000000, readMux(rdSel)};
	end

	// No error response exists in this block
	always @(posedge clock) begin
		if (!resetn)
			hresp <= 1'b0;
		else if (clockEn)
			hresp <= 1'b0;
	end

	// ======================================
	// Software registers
	always @(posedge clock) begin
		if (!resetn)
			modeQ <= `URX_RST_MODE;
		else if (clockEn && wrNow && wrSelQ[`URX_S_MODE])
			modeQ <= (hwdata[7:0] & `URX_MODE_WMSK) | `URX_MODE_FIX;
	end

	always @(posedge clock) begin
		if (!resetn)
			baudQ <= `URX_RST_BAUD;
		else if (clockEn && wrNow && wrSelQ[`URX_S_BAUD])
			baudQ <= hwdata[7:0] & `URX_BAUD_WMSK;
	end

	always @(posedge clock) begin
		if (!resetn)
			dirQ <= `URX_RST_DIR;
		else if (clockEn && wrNow && wrSelQ[`URX_S_DIR])
			dirQ <= hwdata[4:0];
	end

	always @(posedge clock) begin
		if (!resetn)
			latchQ <= `URX_RST_LAT;
		else if (clockEn && wrNow && wrSelQ[`URX_S_LAT])
			latchQ <= hwdata[4:0];
	end

	// ======================================
	// Baud generator and receiver
	wire       halfTick;
	wire       rxDone;
	wire [7:0] rxData;
	wire       rxParity;
	wire       rxStopOk;
	// Receive input reads high while powered down
	wire       rxLine = powerOn ? p3PinIn[`URX_RX_PIN] : 1'b1;

	urx_baud_gen u_baud (
		.clock    (clock),
		.resetn   (resetn),
		.clockEn  (clockEn),
		.run      (powerOn),
		.baseSel  (baseSel),
		.divisor  (divisor),
		.timerOut (eightBitTimerOutput),
		.halfTick (halfTick),
		.baudTick (baudTick)
	);

	urx_rx_frame u_rx (
		.clock     (clock),
		.resetn    (resetn),
		.clockEn   (clockEn),
		.enable    (rxRun),
		.halfTick  (halfTick),
		.rxLine    (rxLine),
		.charLen8  (charLen8),
		.parityOn  (parityOn),
		.done      (rxDone),
		.data      (rxData),
		.parityBit (rxParity),
		.stopOk    (rxStopOk)
	);

	// ======================================
	// Error events
	wire parEvent  = rxDone & parityBad(rxData, charLen8, parMode, rxParity);
	wire frmEvent  = rxDone & ~rxStopOk;
	wire ovrEvent  = rxDone & rxFullQ;
	wire bufStore  = rxDone & ~rxFullQ;

	// ======================================
	// Error flags: a new event beats a status read clear
	always @(posedge clock) begin
		if (!resetn)
			parityErrQ <= 1'b0;
		else if (clockEn) begin
			if (!powerOn || !rxOn)
				parityErrQ <= 1'b0;
			else if (parEvent)
				parityErrQ <= 1'b1;
			else if (errRead)
				parityErrQ <= 1'b0;
		end
	end

	always @(posedge clock) begin
		if (!resetn)
			framingErrQ <= 1'b0;
		else if (clockEn) begin
			if (!powerOn || !rxOn)
				framingErrQ <= 1'b0;
			else if (frmEvent)
				framingErrQ <= 1'b1;
			else if (errRead)
				framingErrQ <= 1'b0;
		end
	end

	// Overrun survives a single enable going low
	always @(posedge clock) begin
		if (!resetn)
			overrunQ <= 1'b0;
		else if (clockEn) begin
			if (!powerOn && !rxOn)
				overrunQ <= 1'b0;
			else if (ovrEvent)
				overrunQ <= 1'b1;
			else if (errRead)
				overrunQ <= 1'b0;
		end
	end

	// ======================================
	// Receive buffer
	always @(posedge clock) begin
		if (!resetn) begin
			rxBufQ  <= `URX_RST_RXBUF;
			rxFullQ <= 1'b0;
		end else if (clockEn) begin
			if (!powerOn) begin
				rxBufQ  <= `URX_RST_RXBUF;
				rxFullQ <= 1'b0;
			end else if (bufStore) begin
				rxBufQ  <= rxData;
				rxFullQ <= 1'b1;
			end else if (bufRead) begin
				rxFullQ <= 1'b0;
			end
		end
	end

	// ======================================
	// Port 3 pins
	// Transmit pin carries serial data only while transmission is on
	wire txActive = powerOn & txOn;
	wire txBit    = txActive ? txSerialData : 1'b1;

	always @(posedge clock) begin
		if (!resetn)
			p3PinOeN <= `URX_RST_DIR;
		else if (clockEn)
			p3PinOeN <= dirQ;
	end

	always @(posedge clock) begin
		if (!resetn) begin
			p3PinOut <= `URX_RST_LAT;
		end else if (clockEn) begin
			p3PinOut              <= latchQ;
			p3PinOut[`URX_TX_PIN] <= latchQ[`URX_TX_PIN] & txBit;
		end
	end

	always @(posedge clock) begin
		if (!resetn)
			txEnable <= 1'b0;
		else if (clockEn)
			txEnable <= txActive;
	end

endmodule // urx_top

// ---- tb/urx_asserts.sv ----
// Concurrent checks on the bus answer, pins and baud tick of the receive block
`include "urx_map.vh"
module urx_asserts (
	// Clock and reset
	input logic        clock,
	input logic        resetn,
	input logic        clockEn,
	// Bus
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic        hreadyout,
	input logic [31:0] hrdata,
	input logic        hresp,
	// Pins and tick
	input logic [4:0]  p3PinOut,
	input logic [4:0]  p3PinOeN,
	input logic        baudTick
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// ======================
	// Helpers
	logic rdGo;
	logic errRd;
	logic wrPh_q;
	assign rdGo = hsel && htrans[1] && hready && clockEn && !hwrite;
	assign errRd = rdGo && haddr == {14'h0000, `URX_IDX_ERR, 2'h0};
	// A read right behind a write is waited too, so fast reads exclude it
	always @(posedge clock)
		wrPh_q <= resetn && hsel && htrans[1] && hready && clockEn && hwrite;
	sequence waitedData;
		!hreadyout ##1 hreadyout;
	endsequence
	// ======================
	// Properties
	a_status_wait: assert property (errRd |=> waitedData)
		else $error("status read not waited exactly one cycle");
	a_status_bits: assert property (errRd ##1 waitedData |-> hrdata[7:3] == 5'h00)
		else $error("status upper bits not zero");
	a_fast_read: assert property (rdGo && !errRd && !wrPh_q |=> hreadyout)
		else $error("plain read was waited");
	a_wait_short: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
		else $error("read data upper lanes not zero");
	a_rdata_hold: assert property (!rdGo ##1 !rdGo |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_tick_pulse: assert property (baudTick |=> !baudTick [*3])
		else $error("baud tick too long or too close");
	a_dir_reset: assert property ($rose(resetn) |-> p3PinOeN == 5'h1F && p3PinOut == 5'h00)
		else $error("port pins not at reset state");
endmodule // urx_asserts

bind urx_top urx_asserts chk (.clock(clock), .resetn(resetn), .clockEn(clockEn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hrdata(hrdata), .hresp(hresp), .p3PinOut(p3PinOut), .p3PinOeN(p3PinOeN),
	.baudTick(baudTick));

// ---- tb/urx_remote_tx.sv ----
// Remote serial transmitter that drives the receive pin
module urx_remote_tx (
	// Clock
	input  logic clock,
	// Serial line
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	int bitClocks = 32;
	// Line idles high between frames, as a real receive line does
	initial line = 1'b1;
	task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic parFlip,
		input logic stopBad, input int idleBits);
		logic       p;
		logic [10:0] bits;
		p = (pm == 2'h1) ? 1'b0 : (pm == 2'h2) ? ~^d : ^d;
		bits = {!stopBad, p ^ parFlip, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i != 9 || pm != 2'h0) begin
				line <= bits[i];
				repeat (bitClocks) @(posedge clock);
			end
		end
		// One stop bit only; a second would be idle line anyway
		// Back to back frames start right away, so no second drive in one step
		if (idleBits > 0) begin
			line <= 1'b1;
			repeat (idleBits * bitClocks) @(posedge clock);
		end
	endtask
endmodule // urx_remote_tx

// ---- tb/test_uart_rx_error_and_baud_gen.sv ----
// Self-checking bench for receive error flags, baud generator and port 3 direction
`include "urx_map.vh"
module test_uart_rx_error_and_baud_gen;
	timeunit 1ns;
	timeprecision 1ps;
	// ======================
	// Signals and model state
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        tmr = 1'b0;
	logic        txd = 1'b0;
	logic [4:0]  pinRand = 5'h00;
	logic        rxLine;
	wire         hreadyout, hresp, txEnable, baudTick;
	wire  [31:0] hrdata;
	wire  [4:0]  p3PinOut, p3PinOeN;
	int          n_fail = 0;
	int          samples_checked = 0;
	logic [7:0]  mStat = 8'h00;
	logic [7:0]  mBuf = 8'hFF;
	logic        mFull = 1'b0;
	logic [1:0]  pm = 2'h0;
	logic [31:0] rd;
	int          k, t0;
	int          pre[4] = '{2, 2, 8, 32};
	always #5 clock = ~clock;
	// Timer runs from time zero; the reset baud value already picks it as base clock
	always @(posedge clock) tmr <= ~tmr;
	always @(posedge clock) pinRand <= 5'($urandom);
	urx_top uut (.clock(clock), .resetn(resetn), .clockEn(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .p3PinOut(p3PinOut),
		.p3PinIn({pinRand[4:3], rxLine, pinRand[1:0]}), .p3PinOeN(p3PinOeN),
		.eightBitTimerOutput(tmr), .txSerialData(txd), .txEnable(txEnable), .baudTick(baudTick));
	urx_remote_tx far (.clock(clock), .line(rxLine));
	// ======================
	// Tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {14'h0000, i, 2'h0};
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input string what, input logic [15:0] i, input logic [7:0] exp);
		bus(1'b0, i, 32'h0);
		chk(what, rd, {24'h000000, exp});
	endtask
	task automatic readStat;
		rdc("status", `URX_IDX_ERR, mStat);
		mStat = 8'h00;
	endtask
	task automatic readBuf;
		rdc("rxbuf", `URX_IDX_RXBUF, mBuf);
		mFull = 1'b0;
	endtask
	// Gap after each write: enables need two base clocks to settle
	task automatic mode(input logic pw, input logic rx);
		bus(1'b1, `URX_IDX_MODE, {24'h000000, pw, 1'b0, rx, pm, 3'b101});
		if (!rx) mStat = mStat & 8'h01;
		if (!pw && !rx) mStat = 8'h00;
		if (!pw) begin
			mBuf = 8'hFF;
			mFull = 1'b0;
		end
		repeat (4) @(posedge clock);
	endtask
	task automatic frame(input logic [7:0] d, input logic pf, input logic sb, input int idle);
		far.send(d, pm, pf, sb, idle);
		mStat = mStat | {5'h00, pf && pm[1], sb, mFull};
		if (!mFull) mBuf = d;
		mFull = 1'b1;
	endtask
	task automatic tally_and_finish;
		$display("Checked %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ======================
	// Main sequence
	initial begin
		void'($urandom(80));
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		rdc("dir", `URX_IDX_PORT3_DIR, 8'hFF);
		rdc("baud", `URX_IDX_BAUD, 8'h1F);
		rdc("status", `URX_IDX_ERR, 8'h00);
		rdc("unmapped", 16'h0100, 8'h00);
		bus(1'b1, `URX_IDX_ERR, 32'hFF);
		rdc("status ro", `URX_IDX_ERR, 8'h00);
		bus(1'b1, `URX_IDX_BAUD, 32'hFF);
		rdc("baud bit5", `URX_IDX_BAUD, 8'hDF);
		bus(1'b1, `URX_IDX_PORT3_DIR, 32'h00);
		rdc("dir fixed", `URX_IDX_PORT3_DIR, 8'hE0);
		bus(1'b1, `URX_IDX_PORT3_DIR, 32'hFD);
		bus(1'b1, `URX_IDX_PORT3_LAT, 32'h02);
		repeat (2) @(posedge clock);
		chk("oe", p3PinOeN, 5'h1D);
		chk("pin out", p3PinOut, 5'h02);
		// Power and transmit on: transmit pin follows the serial data
		bus(1'b1, `URX_IDX_MODE, 32'hC5);
		txd <= 1'b1;
		repeat (3) @(posedge clock);
		chk("tx enable", txEnable, 1'b1);
		chk("tx pin high", p3PinOut, 5'h02);
		txd <= 1'b0;
		repeat (3) @(posedge clock);
		chk("tx pin low", p3PinOut, 5'h00);
		for (int s = 0; s < 4; s++) begin
			k = $urandom_range(31, 8);
			mode(1'b0, 1'b0);
			bus(1'b1, `URX_IDX_BAUD, 32'(s * 64 + k));
			mode(1'b1, 1'b0);
			do @(posedge clock); while (baudTick !== 1'b1);
			t0 = int'($time);
			do @(posedge clock); while (baudTick !== 1'b1);
			chk("baud period", (int'($time) - t0) / 10, 2 * k * pre[s]);
		end
		mode(1'b0, 1'b0);
		bus(1'b1, `URX_IDX_BAUD, 32'h48);
		for (int m = 0; m < 4; m++) begin
			pm = 2'(m);
			mode(1'b1, 1'b0);
			mode(1'b1, 1'b1);
			frame(8'($urandom), 1'b1, 1'b0, 1);
			readStat;
			readBuf;
			frame(8'($urandom), 1'b0, 1'b1, 1);
			readStat;
			readBuf;
		end
		// Back to back with one stop bit, buffer left unread
		frame(8'h5A, 1'b0, 1'b0, 0);
		frame(8'hA5, 1'b1, 1'b0, 1);
		mode(1'b1, 1'b0);
		readStat;
		readStat;
		readBuf;
		mode(1'b1, 1'b1);
		frame(8'($urandom), 1'b0, 1'b1, 1);
		frame(8'($urandom), 1'b0, 1'b0, 1);
		mode(1'b0, 1'b0);
		readStat;
		readBuf;
		chk("tx enable off", txEnable, 1'b0);
		tally_and_finish;
	end
	initial begin
		#500000;
		n_fail++;
		tally_and_finish;
	end
endmodule // test_uart_rx_error_and_baud_gen
